//--- rtl/ccr_defines.svh
// offsets, field positions, reset values and timing counts of the converter link
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// frame layout
`define CCR_CMD_BITS 24
`define CCR_PEC_BITS 32
`define CCR_RW_BIT 23
`define CCR_ADDR_HI_BIT 22
`define CCR_ADDR_LO_BIT 21
`define CCR_SEL_MSB 20
`define CCR_SEL_LSB 16
`define CCR_NOP_WORD 24'h3CE000

// read/write select codes
`define CCR_SEL_SLEW_BASE 5'h14
`define CCR_SEL_BOOST 5'h1A

// converter control fields
`define CCR_COMP_BIT 6
`define CCR_PHASE_LSB 4
`define CCR_FREQ_LSB 2
`define CCR_LIMIT_LSB 0
`define CCR_COMP_RESET 1'b0
`define CCR_PHASE_RESET 2'h0
`define CCR_FREQ_RESET 2'h1
`define CCR_LIMIT_RESET 2'h0

// slew register fields
`define CCR_SLEW_EN_BIT 12
`define CCR_SLEW_RATE_LSB 3
`define CCR_SLEW_STEP_LSB 0

// converter switching, quarter periods of the system clock
`define CCR_CLK_HZ 250000000
`define CCR_OSC_HZ 13000000
`define CCR_F250_HZ 250000
`define CCR_F410_HZ 410000
`define CCR_F650_HZ 650000
`define CCR_QUARTER(f) (`CCR_CLK_HZ / ((f) * 4))

// serial clock timing
`define CCR_CLK_NS 4
`define CCR_SCLK_PERIOD_NS 34
`define CCR_SCLK_HALF_CYC ((`CCR_SCLK_PERIOD_NS + 2 * `CCR_CLK_NS - 1) / (2 * `CCR_CLK_NS))

// host register offsets
`define CCR_OFS_CTRL 8'h00
`define CCR_OFS_CMD 8'h04
`define CCR_OFS_RX 8'h08
`define CCR_OFS_STATUS 8'h0C
`define CCR_CTRL_PEC_BIT 0
`define CCR_STAT_BUSY_BIT 0
`define CCR_STAT_DONE_BIT 1

`endif

//--- rtl/ccr_pkg.sv
// host sequencer state type, plus the crc type and crc helper shared by both link ends
package ccr_pkg;

	typedef enum logic [2:0] {
		HOST_IDLE,
		HOST_LEAD,
		HOST_LOW,
		HOST_HIGH,
		HOST_TAIL
	} ccr_host_state_t;

	typedef logic [7:0] ccr_crc_t;

	// crc-8, polynomial x^8+x^2+x+1, zero seed, msb first
	function automatic ccr_crc_t ccr_crc8(input logic [23:0] data);
		ccr_crc_t c;
		logic fb;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = c[7] ^ data[i];
			c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		return c;
	endfunction

endpackage

//--- rtl/ccr_link_if.sv
// four-wire serial link between host and converter device
`timescale 1ns/1ps
interface ccr_link_if;
	logic sclk;
	logic syncN;
	logic sdi;
	logic sdo;

	modport host (
		output sclk,
		output syncN,
		output sdi,
		input sdo
	);

	modport dev (
		input sclk,
		input syncN,
		input sdi,
		output sdo
	);
endinterface

//--- rtl/ccr_device_end.sv
// converter device end: control decode, slew settings and serial readback
//
// Contract
// - comp bit 0 internal resistor, 1 bypass
// - phase code sets channel switching edges
// - freq code picks 250/410/650 kHz switching
// - limit code picks maximum boost voltage
// - slew settings independent per channel
// - read/write bit 1 starts readback
// - address bits plus select pick register
// - host may send any don't-care bits
// - host follows read with nop or read
// - readback: 8 undefined bits, 16 data
// - sdo changes on rise, sampled on fall
// - pec adds crc byte, 32 bits total
// - host keeps sclk idle between frames
// - read frame bit layout is fixed
// - nop word is 0x3CE000
// - control register field positions
// - slew register field positions
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_device_end #(
	parameter int NCH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial link
	ccr_link_if.dev link,
	// straps and mode
	input wire logic devAddrHi,
	input wire logic devAddrLo,
	input wire logic pecEnable,
	// converter controls
	output logic compBypass,
	output logic [1:0] phaseSelect,
	output logic [1:0] freqSelect,
	output logic [1:0] boostLimit,
	output logic [NCH-1:0] chanSwitch,
	// slew controls, channel a in the low bits
	output logic [NCH-1:0] slewEnable,
	output logic [4*NCH-1:0] slewRate,
	output logic [3*NCH-1:0] slewStep
);

	if (NCH != 4) begin : g_chk
		$error("ccr_device_end serves exactly four channels");
	end

	// link edge detection
	logic sclkPrev_reg;
	logic syncPrev_reg;
	wire inFrame = ~link.syncN;
	wire sclkRise = link.sclk & ~sclkPrev_reg;
	wire sclkFall = ~link.sclk & sclkPrev_reg;
	wire frameStart = syncPrev_reg & ~link.syncN;
	wire frameEnd = ~syncPrev_reg & link.syncN;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclkPrev_reg <= 1'b1;
			syncPrev_reg <= 1'b1;
		end else begin
			sclkPrev_reg <= link.sclk;
			syncPrev_reg <= link.syncN;
		end
	end

	// command shift-in
	logic [23:0] rxShift_reg;
	logic [5:0] rxCount_reg;
	wire rxFull = rxCount_reg == 6'(`CCR_CMD_BITS);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxShift_reg <= 24'h000000;
			rxCount_reg <= 6'h00;
		end else if (frameStart) begin
			rxCount_reg <= 6'h00;
		end else if (inFrame && sclkFall && !rxFull) begin
			rxShift_reg <= {rxShift_reg[22:0], link.sdi};
			rxCount_reg <= rxCount_reg + 6'h01;
		end
	end

	// command decode; extra pec bits from the host are dropped
	// fixed read frame layout
	wire cmdRead = rxShift_reg[`CCR_RW_BIT];
	wire [4:0] cmdSel = rxShift_reg[`CCR_SEL_MSB:`CCR_SEL_LSB];
	wire [15:0] cmdData = rxShift_reg[15:0];
	wire addrHit = (rxShift_reg[`CCR_ADDR_HI_BIT] == devAddrHi) &&
		(rxShift_reg[`CCR_ADDR_LO_BIT] == devAddrLo);
	wire isNop = rxShift_reg == `CCR_NOP_WORD;
	wire cmdDone = frameEnd && rxFull && addrHit;
	wire readCmd = cmdDone && cmdRead;
	wire writeCmd = cmdDone && !cmdRead && !isNop;
	wire wrBoost = writeCmd && (cmdSel == `CCR_SEL_BOOST);
	wire wrSlew = writeCmd && (cmdSel[4:2] == 3'(`CCR_SEL_SLEW_BASE >> 2));
	wire [1:0] wrChan = cmdSel[1:0];

	// converter control register
	logic comp_reg;
	logic [1:0] phase_reg;
	logic [1:0] freq_reg;
	logic [1:0] limit_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			comp_reg <= `CCR_COMP_RESET;
			phase_reg <= `CCR_PHASE_RESET;
			freq_reg <= `CCR_FREQ_RESET;
			limit_reg <= `CCR_LIMIT_RESET;
		end else if (wrBoost) begin
			comp_reg <= cmdData[`CCR_COMP_BIT];
			phase_reg <= cmdData[`CCR_PHASE_LSB +: 2];
			freq_reg <= cmdData[`CCR_FREQ_LSB +: 2];
			limit_reg <= cmdData[`CCR_LIMIT_LSB +: 2];
		end
	end

	// slew registers, one slice per channel
	logic [NCH-1:0] slewEn_reg;
	logic [4*NCH-1:0] slewRate_reg;
	logic [3*NCH-1:0] slewStep_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			slewEn_reg <= '0;
			slewRate_reg <= '0;
			slewStep_reg <= '0;
		end else if (wrSlew) begin
			slewEn_reg[wrChan] <= cmdData[`CCR_SLEW_EN_BIT];
			slewRate_reg[wrChan*4 +: 4] <= cmdData[`CCR_SLEW_RATE_LSB +: 4];
			slewStep_reg[wrChan*3 +: 3] <= cmdData[`CCR_SLEW_STEP_LSB +: 3];
		end
	end

	// readback request
	logic rdPending_reg;
	logic [4:0] rdSel_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdPending_reg <= 1'b0;
			rdSel_reg <= 5'h00;
		end else if (frameEnd) begin
			// any completed frame consumes a pending readback
			rdPending_reg <= readCmd;
			if (readCmd) begin
				rdSel_reg <= cmdSel;
			end
		end
	end

	// readback data selection; other registers live outside this block
	wire selSlew = rdSel_reg[4:2] == 3'(`CCR_SEL_SLEW_BASE >> 2);
	wire selBoost = rdSel_reg == `CCR_SEL_BOOST;
	wire [1:0] rdChan = rdSel_reg[1:0];
	wire [15:0] boostWord = {9'h000, comp_reg, phase_reg, freq_reg, limit_reg};
	wire [15:0] slewWord = {3'h0, slewEn_reg[rdChan], 5'h00,
		slewRate_reg[rdChan*4 +: 4], slewStep_reg[rdChan*3 +: 3]};
	wire [15:0] rdData = selBoost ? boostWord : (selSlew ? slewWord : 16'h0000);
	wire [23:0] rdFrame = {8'h00, rdData};
	wire [7:0] rdCrc = pecEnable ? ccr_pkg::ccr_crc8(rdFrame) : 8'h00;
	wire [31:0] txWord = rdPending_reg ? {rdFrame, rdCrc} : 32'h00000000;

	// serial output shifter
	logic [31:0] txShift_reg;
	logic sdo_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txShift_reg <= 32'h00000000;
			sdo_reg <= 1'b0;
		end else if (frameStart) begin
			sdo_reg <= txWord[31];
			txShift_reg <= {txWord[30:0], 1'b0};
		end else if (inFrame && sclkRise) begin
			sdo_reg <= txShift_reg[31];
			txShift_reg <= {txShift_reg[30:0], 1'b0};
		end else if (!inFrame) begin
			sdo_reg <= 1'b0;
		end
	end

	// converter switching clocks: a quarter-period counter
	// reserved code falls back to default rate
	wire [9:0] quarterLen = (freq_reg == 2'h0) ? 10'(`CCR_QUARTER(`CCR_F250_HZ)) :
		(freq_reg == 2'h2) ? 10'(`CCR_QUARTER(`CCR_F650_HZ)) :
		10'(`CCR_QUARTER(`CCR_F410_HZ));
	logic [9:0] divCnt_reg;
	logic [1:0] quad_reg;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divCnt_reg <= 10'h000;
			quad_reg <= 2'h0;
		end else if (divCnt_reg >= quarterLen - 10'h001) begin
			divCnt_reg <= 10'h000;
			quad_reg <= quad_reg + 2'h1;
		end else begin
			divCnt_reg <= divCnt_reg + 10'h001;
		end
	end

	// quarter offsets d,c,b,a per phase code
	wire [7:0] phaseOffs = (phase_reg == 2'h1) ? 8'hA0 :
		(phase_reg == 2'h2) ? 8'h88 :
		(phase_reg == 2'h3) ? 8'hE4 : 8'h00;
	logic [NCH-1:0] chanSwitch_reg;
	wire [NCH-1:0] chanSwitch_next;

	// one process writes the whole vector, so each bit has one driver
	for (genvar ch = 0; ch < NCH; ch++) begin : g_sw
		wire [1:0] rel = quad_reg - phaseOffs[ch*2 +: 2];
		assign chanSwitch_next[ch] = ~rel[1];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chanSwitch_reg <= '0;
		end else begin
			chanSwitch_reg <= chanSwitch_next;
		end
	end

	// outputs, all from flops
	assign link.sdo = sdo_reg;
	assign compBypass = comp_reg;
	assign phaseSelect = phase_reg;
	assign freqSelect = freq_reg;
	assign boostLimit = limit_reg;
	assign chanSwitch = chanSwitch_reg;
	assign slewEnable = slewEn_reg;
	assign slewRate = slewRate_reg;
	assign slewStep = slewStep_reg;

endmodule

//--- rtl/ccr_host_end.sv
// serial host end: apb registers drive one link frame per command
`timescale 1ns/1ps
`include "ccr_defines.svh"
module ccr_host_end #(
	parameter int HALF = `CCR_SCLK_HALF_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	ccr_link_if.host link
);

	// device needs two cycles to react to an edge
	if (HALF < 2 || HALF > 255) begin : g_chk
		$error("ccr_host_end HALF must lie in 2..255");
	end

	// apb decode: one wait state, writes land on the pready edge
	logic pready_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	wire hitCtrl = paddr == `CCR_OFS_CTRL;
	wire hitCmd = paddr == `CCR_OFS_CMD;
	wire hitRx = paddr == `CCR_OFS_RX;
	wire hitStat = paddr == `CCR_OFS_STATUS;
	wire hitAny = hitCtrl | hitCmd | hitRx | hitStat;
	wire accessWait = psel & penable & ~pready_reg;
	wire writeNow = psel & penable & pwrite & pready_reg & hitAny;

	logic pec_reg;
	logic [23:0] cmd_reg;
	logic [31:0] rxWord_reg;
	logic busy_reg;
	logic done_reg;
	ccr_pkg::ccr_host_state_t state_reg;
	wire startReq = writeNow & hitCmd & ~busy_reg;
	wire frameDone = state_reg == ccr_pkg::HOST_TAIL;

	wire [31:0] rdMux = hitCtrl ? {31'h00000000, pec_reg} :
		hitCmd ? {8'h00, cmd_reg} :
		hitRx ? rxWord_reg :
		hitStat ? {30'h00000000, done_reg, busy_reg} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= accessWait;
			prdata_reg <= (accessWait && !pwrite) ? rdMux : 32'h00000000;
			pslverr_reg <= accessWait & ~hitAny;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pec_reg <= 1'b0;
			cmd_reg <= 24'h000000;
		end else begin
			if (writeNow && hitCtrl) begin
				pec_reg <= pwdata[`CCR_CTRL_PEC_BIT];
			end
			if (startReq) begin
				cmd_reg <= pwdata[23:0];
			end
		end
	end

	// frame sequencer; sclk idles high, each bit is fall then rise
	logic [7:0] halfCnt_reg;
	logic [5:0] bitCnt_reg;
	logic [31:0] txShift_reg;
	logic sclk_reg;
	logic syncN_reg;
	logic sdi_reg;
	wire halfDone = halfCnt_reg == 8'(HALF - 1);
	wire [5:0] nBits = pec_reg ? 6'(`CCR_PEC_BITS) : 6'(`CCR_CMD_BITS);
	wire [31:0] txWord = {pwdata[23:0],
		pec_reg ? ccr_pkg::ccr_crc8(pwdata[23:0]) : 8'h00};
	wire stepState = (state_reg != ccr_pkg::HOST_IDLE) && halfDone;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ccr_pkg::HOST_IDLE;
			halfCnt_reg <= 8'h00;
			bitCnt_reg <= 6'h00;
			txShift_reg <= 32'h00000000;
			rxWord_reg <= 32'h00000000;
			sclk_reg <= 1'b1;
			syncN_reg <= 1'b1;
			sdi_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			halfCnt_reg <= (stepState || state_reg == ccr_pkg::HOST_IDLE) ?
				8'h00 : halfCnt_reg + 8'h01;
			unique case (state_reg)
				ccr_pkg::HOST_IDLE: begin
					if (startReq) begin
						state_reg <= ccr_pkg::HOST_LEAD;
						busy_reg <= 1'b1;
						syncN_reg <= 1'b0;
						sdi_reg <= txWord[31];
						txShift_reg <= {txWord[30:0], 1'b0};
						bitCnt_reg <= 6'h00;
						rxWord_reg <= 32'h00000000;
					end
				end
				ccr_pkg::HOST_LEAD, ccr_pkg::HOST_LOW: begin
					if (halfDone && state_reg == ccr_pkg::HOST_LEAD) begin
						state_reg <= ccr_pkg::HOST_LOW;
						sclk_reg <= 1'b0;
						rxWord_reg <= {rxWord_reg[30:0], link.sdo};
					end else if (halfDone) begin
						state_reg <= ccr_pkg::HOST_HIGH;
						sclk_reg <= 1'b1;
						bitCnt_reg <= bitCnt_reg + 6'h01;
						sdi_reg <= txShift_reg[31];
						txShift_reg <= {txShift_reg[30:0], 1'b0};
					end
				end
				ccr_pkg::HOST_HIGH: begin
					if (halfDone && bitCnt_reg == nBits) begin
						state_reg <= ccr_pkg::HOST_TAIL;
					end else if (halfDone) begin
						state_reg <= ccr_pkg::HOST_LOW;
						sclk_reg <= 1'b0;
						rxWord_reg <= {rxWord_reg[30:0], link.sdo};
					end
				end
				ccr_pkg::HOST_TAIL: begin
					// sclk stays high until next frame
					state_reg <= ccr_pkg::HOST_IDLE;
					syncN_reg <= 1'b1;
					sdi_reg <= 1'b0;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end

	// done flag: completion wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			done_reg <= 1'b0;
		end else if (frameDone) begin
			done_reg <= 1'b1;
		end else if (writeNow && hitStat && pwdata[`CCR_STAT_DONE_BIT]) begin
			done_reg <= 1'b0;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign link.sclk = sclk_reg;
	assign link.syncN = syncN_reg;
	assign link.sdi = sdi_reg;

endmodule

//--- testbench/ccr_link_asserts.sv
// checks on the four serial wires between the two ends
`timescale 1ns/1ps
module ccr_link_asserts #(
	parameter int HALF = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// serial link
	input wire logic sclk,
	input wire logic syncN,
	input wire logic sdi,
	input wire logic sdo
);
	int lowCnt;
	int highCnt;
	int fallCnt;
	// counters rebuilt from the wires, not from the ends
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lowCnt <= 0;
			highCnt <= 0;
			fallCnt <= 0;
		end else begin
			lowCnt <= sclk ? 0 : lowCnt + 1;
			highCnt <= (sclk && !syncN) ? highCnt + 1 : 0;
			fallCnt <= syncN ? 0 : fallCnt + int'(!sclk && lowCnt == 0);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	idle_sclk_a: assert property (syncN |-> sclk)
		else $error("sclk low outside a frame");
	sdo_idle_a: assert property (syncN && $past(syncN) |-> !sdo)
		else $error("sdo not low outside a frame");
	sdo_edge_a: assert property ($changed(sdo) |-> sclk)
		else $error("sdo moved while sclk low");
	low_half_a: assert property ($rose(sclk) |-> lowCnt == HALF)
		else $error("sclk low phase has wrong length");
	high_half_a: assert property ($fell(sclk) && !syncN |-> highCnt == HALF)
		else $error("sclk high phase has wrong length");
	// host holds sclk high one extra cycle in its tail state before raising syncN
	tail_half_a: assert property ($rose(syncN) |-> highCnt == HALF + 1)
		else $error("frame end spacing wrong");
	frame_len_a: assert property ($rose(syncN) |-> fallCnt == 24 || fallCnt == 32)
		else $error("frame bit count wrong");
	lead_zero_a: assert property ($fell(sclk) && !syncN && fallCnt < 8 |-> !sdo)
		else $error("upper readback bits not low");
	cover property ($rose(syncN) && fallCnt == 32);
	cover property ($rose(syncN) && fallCnt == 24);
	cover property (!syncN && sdo);
	cover property (!syncN && sdi);
endmodule

//--- testbench/test_converter_cfg_and_readback.sv
// bench joining host and device ends, driven over apb
`timescale 1ns/1ps
`include "ccr_defines.svh"
module test_converter_cfg_and_readback;
	logic clk, rst_n, psel, penable, pwrite, pecEnable, pready, pslverr, compBypass, rerr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic [1:0] phaseSelect, freqSelect, boostLimit;
	logic [3:0] chanSwitch, slewEnable;
	logic [15:0] slewRate;
	logic [11:0] slewStep;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	ccr_link_if link();
	ccr_host_end #(.HALF(2)) ccr_host_end_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link(link));
	// straps fixed at device address 2
	ccr_device_end ccr_device_end_inst (.clk(clk), .rst_n(rst_n), .link(link), .devAddrHi(1'b1),
		.devAddrLo(1'b0), .pecEnable(pecEnable), .compBypass(compBypass),
		.phaseSelect(phaseSelect), .freqSelect(freqSelect), .boostLimit(boostLimit),
		.chanSwitch(chanSwitch), .slewEnable(slewEnable), .slewRate(slewRate),
		.slewStep(slewStep));
	ccr_link_asserts #(.HALF(2)) ccr_link_asserts_inst (.clk(clk), .rst_n(rst_n),
		.sclk(link.sclk), .syncN(link.syncN), .sdi(link.sdi), .sdo(link.sdo));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_count++;
			end_of_test();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one frame, then wait for done and clear it
	task automatic frame(input logic [23:0] cmd);
		apb(1'b1, `CCR_OFS_CMD, {8'h00, cmd});
		do apb(1'b0, `CCR_OFS_STATUS, 32'h0); while (rdata[`CCR_STAT_DONE_BIT] !== 1'b1);
		apb(1'b1, `CCR_OFS_STATUS, 32'h2);
	endtask
	function automatic logic [7:0] crc(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	task automatic t_reset();
		check(32'({compBypass, phaseSelect, freqSelect, boostLimit}), 32'h04);
		check(32'({slewEnable, slewRate, slewStep}), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check(32'(rerr), 32'h1);
		$display("test reset done");
	endtask
	task automatic t_ctrl();
		logic [6:0] f;
		logic [3:0] e;
		int q;
		int n;
		for (int i = 0; i < 4; i++) begin
			f = {i[0], i[1:0], i[1:0], i[1:0]};
			q = (i == 0) ? 250 : (i == 2) ? 96 : 152;
			e = (i == 0) ? 4'hF : (i == 1) ? 4'h3 : 4'h5;
			frame({8'h5A, 9'h1FF, f});
			check(32'({compBypass, phaseSelect, freqSelect, boostLimit}), 32'(f));
			frame({8'hDA, 16'h5A5A});
			check(32'({compBypass, phaseSelect, freqSelect, boostLimit}), 32'(f));
			frame(`CCR_NOP_WORD);
			apb(1'b0, `CCR_OFS_RX, 32'h0);
			check(rdata, 32'(f));
			while (chanSwitch[0] !== 1'b0) @(posedge clk);
			while (chanSwitch[0] !== 1'b1) @(posedge clk);
			n = 0;
			while (chanSwitch[0] !== 1'b0) begin
				@(posedge clk);
				n++;
			end
			while (chanSwitch[0] !== 1'b1) begin
				@(posedge clk);
				n++;
			end
			check(32'(n), 32'(4 * q));
			repeat (q / 2) @(posedge clk);
			// quarter 0: with offsets 0,1,2,3 only a and d are high
			if (i < 3)
				check(32'(chanSwitch), 32'(e));
			else
				check(32'(chanSwitch), 32'h9);
		end
		frame(24'h3A0000);
		check(32'({compBypass, phaseSelect, freqSelect, boostLimit}), 32'h7F);
		apb(1'b0, `CCR_OFS_CMD, 32'h0);
		check(rdata, 32'h3A0000);
		$display("test control done");
	endtask
	task automatic t_slew();
		logic [15:0] d [4];
		for (int c = 0; c < 4; c++) begin
			d[c] = {3'h0, c[0], 5'h00, 4'(3 * c + 5), 3'(c + 1)};
			frame({8'h54 + 8'(c), d[c]});
		end
		check(32'(slewEnable), 32'hA);
		check(32'(slewRate), 32'hEB85);
		check(32'(slewStep), 32'h8D1);
		frame(24'hD40000);
		frame(24'hD50000);
		apb(1'b0, `CCR_OFS_RX, 32'h0);
		check(rdata, 32'(d[0]));
		frame(`CCR_NOP_WORD);
		apb(1'b0, `CCR_OFS_RX, 32'h0);
		check(rdata, 32'(d[1]));
		apb(1'b1, `CCR_OFS_CTRL, 32'h1);
		pecEnable <= 1'b1;
		frame(24'hD70000);
		frame(`CCR_NOP_WORD);
		apb(1'b0, `CCR_OFS_RX, 32'h0);
		check(rdata, {8'h00, d[3], crc({8'h00, d[3]})});
		apb(1'b1, `CCR_OFS_CTRL, 32'h0);
		pecEnable <= 1'b0;
		$display("test slew done");
	endtask
	initial begin
		rst_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		pecEnable <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_ctrl();
		t_slew();
		end_of_test();
	end
endmodule
